/* rtl/apr_readout.sv */
// Purpose: Absolute position readout over reassigned pins and parameters
// Assumes: All inputs synchronous to clock; parameter port one access a cycle
// Notes:   Reassigned pins are handed back when a frame ends or aborts
`timescale 1ns/100ps
`default_nettype none
module apr_readout
	import apr_pkg::*;
#(
	parameter int unsigned CYC_PER_MS   = MS_CYC,
	parameter int unsigned TIMEOUT_CYC  = RESP_TIMEOUT_CYC,
	parameter int unsigned ACK_CYC      = ACK_CONFIRM_CYC
) (
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              param_wr,
	input  wire logic              param_rd,
	input  wire logic [15:0]       param_addr,
	input  wire logic [31:0]       param_wdata,
	output logic      [31:0]       param_rdata,
	output logic                   param_rvalid,
	input  wire logic              position_register_mode,
	input  wire logic [ST_W-1:0]   enc_status,
	input  wire logic [15:0]       enc_turns,
	input  wire logic [31:0]       enc_pulse,
	input  wire logic [31:0]       user_unit_count,
	input  wire logic              readout_enable,
	input  wire logic              fourth_input_pin,
	input  wire logic              second_output_func,
	input  wire logic              third_output_func,
	output logic                   second_output_pin,
	output logic                   third_output_pin,
	output logic                   fourth_input_func,
	output logic                   readout_active,
	output logic                   readout_error_flag,
	output logic                   coord_init,
	output logic                   coord_reset
);

	typedef enum logic [2:0] {
		S_OFF, S_SETTLE, S_IDLE, S_LOAD, S_READY, S_CONFIRM, S_NEXT, S_HALT
	} apr_state_t;

	apr_state_t state_r;
	apr_state_t state_nxt;

	logic [15:0]        unlock_r;
	logic [15:0]        debounce_r;
	logic [15:0]        enc_mode_r;
	logic [FMT_W-1:0]   format_r;
	logic [15:0]        home_trg_r;
	logic [15:0]        refresh_r;
	logic [15:0]        status_res_r;
	logic [31:0]        res_first_r;
	logic [31:0]        res_second_r;
	logic               refresh_busy_r;
	logic [FRAME_BITS-1:0] frame_r;
	logic [63:0]        frame_low;
	logic [15:0]        frame_sum;
	logic [6:0]         bit_r;
	logic               data_r;
	logic               err_r;
	logic [31:0]        cyc_r;
	logic [15:0]        ms_r;
	logic [31:0]        wait_r;
	logic               ms_tick;
	logic               fault;
	logic               ack_done;
	logic               timed_out;
	logic               home_ok;

	// Lost, low battery or turn overflow cannot be cleared by the link
	assign fault = enc_status[ST_LOST] | enc_status[ST_LOWBAT]
		| enc_status[ST_TURN_OVF];

	// Status word padded to 16 bits, reserved bits zero
	function automatic logic [15:0] status_word();
		status_word = {{(16 - ST_W){1'b0}}, enc_status};
	endfunction

	// Write decode helpers
	assign home_ok = (param_addr == ADDR_HOME_TRG) && param_wr
		&& (param_wdata[15:0] == HOME_GO) && (unlock_r == UNLOCK_KEY)
		&& !position_register_mode;

	// Parameter storage
	always_ff @(posedge clock) begin
		if (!nrst) begin
			unlock_r   <= RST_PARAM16;
			debounce_r <= RST_PARAM16;
			enc_mode_r <= RST_PARAM16;
			format_r   <= '0;
			home_trg_r <= RST_PARAM16;
		end else if (param_wr) begin
			if (param_addr == ADDR_UNLOCK) begin
				unlock_r <= param_wdata[15:0];
			end else if (param_addr == ADDR_DEBOUNCE) begin
				debounce_r <= param_wdata[15:0];
			end else if (param_addr == ADDR_ENC_MODE) begin
				enc_mode_r <= {15'h0000, param_wdata[0]};
			end else if (param_addr == ADDR_FORMAT) begin
				format_r <= param_wdata[FMT_W-1:0];
			end else if (home_ok) begin
				home_trg_r <= HOME_GO;
			end
		end
	end

	// Homing start pulse, only for an accepted trigger write
	always_ff @(posedge clock) begin
		if (!nrst) begin
			coord_init <= 1'b0;
		end else begin
			coord_init <= home_ok;
		end
	end

	// Refresh command: latch, copy results, then clear
	always_ff @(posedge clock) begin
		if (!nrst) begin
			refresh_r      <= RST_PARAM16;
			refresh_busy_r <= 1'b0;
			status_res_r   <= RST_PARAM16;
			res_first_r    <= RST_PARAM32;
			res_second_r   <= RST_PARAM32;
			coord_reset    <= 1'b0;
		end else begin
			coord_reset <= 1'b0;
			if (refresh_busy_r) begin
				status_res_r <= status_word();
				if (format_r[FMT_COMM_BIT]) begin
					res_first_r  <= enc_pulse;
					res_second_r <= {{16{enc_turns[15]}}, enc_turns};
				end else begin
					res_first_r  <= user_unit_count;
					res_second_r <= RST_PARAM32;
				end
				coord_reset    <= (refresh_r == REFRESH_RESET);
				refresh_busy_r <= 1'b0;
				refresh_r      <= RST_PARAM16;
			end else if (param_wr && param_addr == ADDR_REFRESH
				&& (param_wdata[15:0] == REFRESH_READ
				|| param_wdata[15:0] == REFRESH_RESET)) begin
				refresh_r      <= param_wdata[15:0];
				refresh_busy_r <= 1'b1;
			end
		end
	end

	// Registered read port, unmapped addresses read zero
	always_ff @(posedge clock) begin
		if (!nrst) begin
			param_rdata  <= RST_PARAM32;
			param_rvalid <= 1'b0;
		end else begin
			param_rvalid <= param_rd;
			if (!param_rd) begin
				param_rdata <= param_rdata;
			end else if (param_addr == ADDR_UNLOCK) begin
				param_rdata <= {16'h0000, unlock_r};
			end else if (param_addr == ADDR_DEBOUNCE) begin
				param_rdata <= {16'h0000, debounce_r};
			end else if (param_addr == ADDR_ENC_MODE) begin
				param_rdata <= {16'h0000, enc_mode_r};
			end else if (param_addr == ADDR_FORMAT) begin
				param_rdata <= {29'h0000_0000, format_r};
			end else if (param_addr == ADDR_HOME_TRG) begin
				param_rdata <= {16'h0000, home_trg_r};
			end else if (param_addr == ADDR_REFRESH) begin
				param_rdata <= {16'h0000, refresh_r};
			end else if (param_addr == ADDR_STATUS) begin
				param_rdata <= {16'h0000, status_res_r};
			end else if (param_addr == ADDR_RES_1ST) begin
				param_rdata <= res_first_r;
			end else if (param_addr == ADDR_RES_2ND) begin
				param_rdata <= res_second_r;
			end else begin
				param_rdata <= RST_PARAM32;
			end
		end
	end

	// Frame low 64 bits by format, checksum over them
	always_comb begin
		if (format_r[FMT_DIO_BIT]) begin
			frame_low = {enc_pulse, enc_turns, status_word()};
		end else begin
			frame_low = {user_unit_count, 16'h0000, status_word()};
		end
	end

	apr_checksum u_sum (
		.frame_low (frame_low),
		.sum       (frame_sum)
	);

	// Millisecond tick, restarted on every state change
	assign ms_tick = (cyc_r == CYC_PER_MS - 1);

	always_ff @(posedge clock) begin
		if (!nrst || state_r != state_nxt) begin
			cyc_r <= '0;
			ms_r  <= '0;
		end else if (ms_tick) begin
			cyc_r <= '0;
			ms_r  <= ms_r + 16'h0001;
		end else begin
			cyc_r <= cyc_r + 32'h0000_0001;
		end
	end

	// Cycle wait counter for confirm and timeout
	assign ack_done  = (wait_r >= ACK_CYC - 1);
	assign timed_out = (wait_r >= TIMEOUT_CYC - 1);

	always_ff @(posedge clock) begin
		if (!nrst || state_r != state_nxt) begin
			wait_r <= '0;
		end else if (wait_r != 32'hFFFF_FFFF) begin
			wait_r <= wait_r + 32'h0000_0001;
		end
	end

	// Handshake sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_OFF: begin
				if (readout_enable && enc_mode_r[0] && !fault) begin
					state_nxt = S_SETTLE;
				end
			end
			S_SETTLE: begin
				if (ms_r >= debounce_r + SETTLE_EXTRA_MS[15:0]) begin
					state_nxt = S_IDLE;
				end
			end
			S_IDLE: begin
				if (!fourth_input_pin) begin
					state_nxt = S_LOAD;
				end
			end
			S_LOAD: begin
				state_nxt = S_READY;
			end
			S_READY: begin
				if (fourth_input_pin) begin
					state_nxt = S_CONFIRM;
				end else if (timed_out) begin
					state_nxt = S_HALT;
				end
			end
			S_CONFIRM: begin
				if (!fourth_input_pin) begin
					state_nxt = S_READY;
				end else if (ack_done) begin
					state_nxt = (bit_r == LAST_BIT) ? S_HALT : S_NEXT;
				end
			end
			S_NEXT: begin
				if (!fourth_input_pin) begin
					state_nxt = S_LOAD;
				end else if (timed_out) begin
					state_nxt = S_HALT;
				end
			end
			default: begin
				state_nxt = S_HALT;
			end
		endcase
		if (!readout_enable) begin
			state_nxt = S_OFF;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_r <= S_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Frame snapshot when pins are taken over
	always_ff @(posedge clock) begin
		if (!nrst) begin
			frame_r <= '0;
		end else if (state_r == S_SETTLE && state_nxt == S_IDLE) begin
			frame_r <= {frame_sum, frame_low};
		end
	end

	// Bit index and data line, ascending from bit 0
	always_ff @(posedge clock) begin
		if (!nrst) begin
			bit_r  <= '0;
			data_r <= 1'b0;
		end else begin
			if (state_r == S_SETTLE) begin
				bit_r <= '0;
			end else if (state_r == S_CONFIRM && state_nxt == S_NEXT) begin
				bit_r <= bit_r + 7'h01;
			end
			if (state_r == S_LOAD) begin
				data_r <= frame_r[bit_r];
			end
		end
	end

	// Timeout error, cleared only while enable is low
	always_ff @(posedge clock) begin
		if (!nrst) begin
			err_r <= 1'b0;
		end else if ((state_r == S_READY || state_r == S_NEXT)
			&& state_nxt == S_HALT) begin
			err_r <= 1'b1;
		end else if (!readout_enable) begin
			err_r <= 1'b0;
		end
	end

	// Persistent fault keeps the flag up across enable cycles
	assign readout_error_flag = err_r | fault;

	// Pin reassignment while the link owns the pins
	assign readout_active = (state_r == S_IDLE) || (state_r == S_LOAD)
		|| (state_r == S_READY) || (state_r == S_CONFIRM)
		|| (state_r == S_NEXT);

	// Ready is high from placement until confirm time ends
	assign second_output_pin = readout_active
		? (state_r == S_READY || state_r == S_CONFIRM)
		: second_output_func;
	assign third_output_pin  = readout_active ? data_r : third_output_func;

	// Original input function keeps seeing the pin; a high at
	// switch-on is the same level for both uses
	assign fourth_input_func = fourth_input_pin;

endmodule
`default_nettype wire

/* include/apr_pkg.sv */
// Purpose: Shared constants for the absolute position readout block
// Assumes: 200 MHz clock, parameter port with 16-bit parameter addresses
// Notes:   Timing figures kept in their own unit, cycle counts derived
`default_nettype none
package apr_pkg;

	// Clock
	localparam int unsigned CLK_MHZ = 200;

	// Parameter addresses
	localparam logic [15:0] ADDR_UNLOCK   = 16'h0210;
	localparam logic [15:0] ADDR_DEBOUNCE = 16'h0212;
	localparam logic [15:0] ADDR_ENC_MODE = 16'h028A;
	localparam logic [15:0] ADDR_FORMAT   = 16'h028C;
	localparam logic [15:0] ADDR_HOME_TRG = 16'h028E;
	localparam logic [15:0] ADDR_REFRESH  = 16'h0062;
	localparam logic [15:0] ADDR_STATUS   = 16'h0064;
	localparam logic [15:0] ADDR_RES_1ST  = 16'h0066;
	localparam logic [15:0] ADDR_RES_2ND  = 16'h0068;

	// Reset values
	localparam logic [15:0] RST_PARAM16 = 16'h0000;
	localparam logic [31:0] RST_PARAM32 = 32'h0000_0000;

	// Key values and commands
	localparam logic [15:0] UNLOCK_KEY    = 16'h010F;
	localparam logic [15:0] HOME_GO       = 16'h0001;
	localparam logic [15:0] REFRESH_READ  = 16'h0001;
	localparam logic [15:0] REFRESH_RESET = 16'h0002;

	// Field positions
	localparam int unsigned FMT_DIO_BIT  = 0;
	localparam int unsigned FMT_COMM_BIT = 1;
	localparam int unsigned FMT_W        = 3;
	localparam int unsigned ST_LOST      = 0;
	localparam int unsigned ST_LOWBAT    = 1;
	localparam int unsigned ST_TURN_OVF  = 2;
	localparam int unsigned ST_UNIT_OVF  = 3;
	localparam int unsigned ST_UNSET     = 4;
	localparam int unsigned ST_W         = 5;

	// Frame
	localparam int unsigned FRAME_BITS = 80;
	localparam logic [6:0]  LAST_BIT   = 7'h4F;

	// Checksum constants
	localparam logic [15:0] CK_K0 = 16'hA700;
	localparam logic [15:0] CK_K1 = 16'h605A;
	localparam logic [15:0] CK_K2 = 16'h30A5;
	localparam logic [15:0] CK_K3 = 16'h5A06;

	// Timing
	localparam int unsigned SETTLE_EXTRA_MS = 2;
	localparam int unsigned MS_CYC          = CLK_MHZ * 1000;
	localparam int unsigned RESP_TIMEOUT_MS = 200;
	localparam int unsigned RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * MS_CYC;
	localparam int unsigned ACK_CONFIRM_US  = 10;
	localparam int unsigned ACK_CONFIRM_CYC = ACK_CONFIRM_US * CLK_MHZ;

endpackage
`default_nettype wire

/* rtl/apr_checksum.sv */
// Purpose: Frame checksum over the four low words of the frame
// Assumes: Unsigned 16-bit arithmetic, carries dropped
// Notes:   Purely combinational; caller registers the result
`timescale 1ns/100ps
`default_nettype none
module apr_checksum
	import apr_pkg::*;
(
	input  wire logic [63:0] frame_low,
	output logic      [15:0] sum
);

	logic [15:0] s0;
	logic [15:0] s1;
	logic [15:0] s2;

	// Add and xor chain, word 0 is the status word
	always_comb begin
		s0  = (frame_low[15:0] + CK_K0) ^ frame_low[31:16];
		s1  = (s0 + CK_K1) ^ frame_low[47:32];
		s2  = (s1 + CK_K2) ^ frame_low[63:48];
		sum = s2 + CK_K3;
	end

endmodule
`default_nettype wire

/* test/apr_readout_properties.sv */
// Purpose: Port checks for the readout block
// Assumes: Bound into apr_readout; one clock, sync reset
// Notes:   Handshake checks hold only while the pins are reassigned
`timescale 1ns/100ps
`default_nettype none
module apr_readout_checker
	import apr_pkg::*;
#(
	parameter int unsigned ACK_CYC = ACK_CONFIRM_CYC
) (
	input wire logic            clock,
	input wire logic            nrst,
	input wire logic            param_wr,
	input wire logic            param_rd,
	input wire logic [15:0]     param_addr,
	input wire logic [31:0]     param_wdata,
	input wire logic            param_rvalid,
	input wire logic            position_register_mode,
	input wire logic [ST_W-1:0] enc_status,
	input wire logic            readout_enable,
	input wire logic            fourth_input_pin,
	input wire logic            second_output_func,
	input wire logic            second_output_pin,
	input wire logic            readout_active,
	input wire logic            readout_error_flag,
	input wire logic            coord_init,
	input wire logic            coord_reset
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	logic [15:0] hi_cnt_r;

	// Request high run length; saturates so a long idle never wraps
	always_ff @(posedge clock) begin
		if (!nrst || !fourth_input_pin)
			hi_cnt_r <= 16'h0000;
		else if (hi_cnt_r != 16'hFFFF)
			hi_cnt_r <= hi_cnt_r + 16'h0001;
	end

	// Bit handshake on the reassigned pins
	ready_rise_a: assert property (
		$fell(fourth_input_pin) && readout_active && !second_output_pin |-> ##2 second_output_pin)
		else $error("ready late after request");
	ready_drop_a: assert property (
		$fell(second_output_pin) && readout_active && $past(readout_active)
		|-> hi_cnt_r >= ACK_CYC - 1) else $error("ready dropped before confirm");
	ready_return_a: assert property (
		!readout_active |-> second_output_pin == second_output_func)
		else $error("output pin not handed back");
	start_gate_a: assert property (
		$rose(readout_active) |-> $past(readout_enable) && $past(enc_status[2:0]) == 3'b000)
		else $error("pins taken without enable or with fault");

	// Error flag
	fault_flag_a: assert property (
		|enc_status[2:0] |-> readout_error_flag) else $error("fault not flagged");
	error_clear_a: assert property (
		!readout_enable ##1 enc_status[2:0] == 3'b000 |-> !readout_error_flag)
		else $error("error kept after enable low");

	// Parameter side effects
	home_cause_a: assert property (
		coord_init |-> $past(param_wr && param_addr == ADDR_HOME_TRG
		&& param_wdata[15:0] == HOME_GO && !position_register_mode))
		else $error("coordinate init without trigger");
	refresh_reset_a: assert property (
		coord_reset |-> $past(param_wr && param_addr == ADDR_REFRESH
		&& param_wdata[15:0] == REFRESH_RESET, 2)) else $error("coordinate reset without cmd");
	rvalid_timing_a: assert property (
		param_rvalid == $past(param_rd)) else $error("read valid misplaced");
endmodule

bind apr_readout apr_readout_checker #(.ACK_CYC(ACK_CYC)) u_chk (
	.clock(clock), .nrst(nrst), .param_wr(param_wr), .param_rd(param_rd),
	.param_addr(param_addr), .param_wdata(param_wdata), .param_rvalid(param_rvalid),
	.position_register_mode(position_register_mode), .enc_status(enc_status),
	.readout_enable(readout_enable), .fourth_input_pin(fourth_input_pin),
	.second_output_func(second_output_func), .second_output_pin(second_output_pin),
	.readout_active(readout_active), .readout_error_flag(readout_error_flag),
	.coord_init(coord_init), .coord_reset(coord_reset)
);
`default_nettype wire

/* test/apr_host_model.sv */
// Purpose: Host side of the bit-serial readout handshake
// Assumes: Driven off the falling edge, pins already reassigned
// Notes:   Only misbehaviour offered is a stalled acknowledge
`timescale 1ns/100ps
`default_nettype none
module apr_host_model (
	input  wire logic clock,
	input  wire logic ready,
	input  wire logic data,
	output var logic  request
);
	localparam int WAIT_MAX = 50;
	// Idle high so switch-on never looks like a request
	initial request = 1'b1;

	// Bounded wait for a ready level; late means a broken link
	task automatic wait_ready(input logic lvl, output bit late);
		int t;
		t = 0;
		while (ready !== lvl && t < WAIT_MAX) begin
			@(negedge clock);
			t++;
		end
		late = (t >= WAIT_MAX);
	endtask

	// One frame, bit 0 first; stall withholds the first acknowledge
	task automatic read_frame(input bit stall, input int hold, output logic [79:0] f,
		output bit fault);
		bit late;
		fault = 1'b0;
		f = '0;
		for (int i = 0; i < 80 && !fault; i++) begin
			wait_ready(1'b0, late);
			request = 1'b0;
			wait_ready(1'b1, late);
			fault = late;
			f[i] = data;
			if (stall) begin
				repeat (hold) @(negedge clock);
				fault = 1'b1;
			end
			request = 1'b1;
		end
	endtask
endmodule
`default_nettype wire

/* test/tb_absolute_position_readout.sv */
// Purpose: Self-checking bench for the position readout block
// Assumes: Counts shortened: 20 cycles a millisecond, 8-cycle confirm
// Notes:   Bit handshake comes from the host model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_absolute_position_readout;
	import apr_pkg::*;
	localparam int unsigned CPM     = 20;
	localparam int unsigned TMO     = 2000;
	localparam int unsigned ACK     = 8;
	localparam int          RESTART = 10;
	localparam int          LIMIT   = 30000;
	logic            clock, nrst, param_wr, param_rd, param_rvalid, position_register_mode;
	logic [15:0]     param_addr, enc_turns;
	logic [31:0]     param_wdata, param_rdata, enc_pulse, user_unit_count;
	logic [ST_W-1:0] enc_status;
	logic            readout_enable, fourth_input_pin, second_output_func, third_output_func;
	logic            second_output_pin, third_output_pin, fourth_input_func, readout_active;
	logic            readout_error_flag, coord_init, coord_reset;
	int              n_mismatch, n_tests, n_init, n_rst, cyc;

	apr_readout #(.CYC_PER_MS(CPM), .TIMEOUT_CYC(TMO), .ACK_CYC(ACK)) dut (
		.clock(clock), .nrst(nrst), .param_wr(param_wr), .param_rd(param_rd),
		.param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
		.param_rvalid(param_rvalid), .position_register_mode(position_register_mode),
		.enc_status(enc_status), .enc_turns(enc_turns), .enc_pulse(enc_pulse),
		.user_unit_count(user_unit_count), .readout_enable(readout_enable),
		.fourth_input_pin(fourth_input_pin), .second_output_func(second_output_func),
		.third_output_func(third_output_func), .second_output_pin(second_output_pin),
		.third_output_pin(third_output_pin), .fourth_input_func(fourth_input_func),
		.readout_active(readout_active), .readout_error_flag(readout_error_flag),
		.coord_init(coord_init), .coord_reset(coord_reset));
	apr_host_model host (.clock(clock), .ready(second_output_pin), .data(third_output_pin),
		.request(fourth_input_pin));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Pulse counters and hang guard
	always @(posedge clock) begin
		cyc++;
		if (coord_init === 1'b1) n_init++;
		if (coord_reset === 1'b1) n_rst++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Parameter port; an idle cycle after each access keeps writes apart
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		param_addr = a;
		param_wdata = d;
		param_wr = 1'b1;
		@(negedge clock);
		param_wr = 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		param_addr = a;
		param_rd = 1'b1;
		@(negedge clock);
		param_rd = 1'b0;
		`CHK(param_rvalid, 1'b1)
		`CHK(param_rdata, e)
		@(negedge clock);
	endtask

	function automatic logic [79:0] exp_frame(input bit pulse);
		logic [63:0] lo;
		logic [15:0] c;
		lo = {pulse ? enc_pulse : user_unit_count, pulse ? enc_turns : 16'h0000,
			11'h000, enc_status};
		c = lo[15:0] + CK_K0;
		c = (c ^ lo[31:16]) + CK_K1;
		c = (c ^ lo[47:32]) + CK_K2;
		c = (c ^ lo[63:48]) + CK_K3;
		return {c, lo};
	endfunction

	// Raise enable; pins switch once the settle window ends, debounce db ms
	task automatic start_link(input logic on, input int unsigned db);
		readout_enable = 1'b1;
		repeat (((SETTLE_EXTRA_MS + db) * CPM) - 5) @(negedge clock);
		`CHK(readout_active, 1'b0)
		for (int t = 0; t < 8 * CPM + 5 && readout_active !== 1'b1; t++)
			@(negedge clock);
		`CHK(readout_active, on)
	endtask
	task automatic stop_link();
		readout_enable = 1'b0;
		repeat (RESTART) @(negedge clock);
	endtask

	task automatic t_regs();
		rd(ADDR_ENC_MODE, 32'h0000_0000);
		rd(16'h0000, 32'h0000_0000);
		start_link(1'b0, 0);
		stop_link();
		wr(ADDR_ENC_MODE, 32'h0000_0001);
		rd(ADDR_ENC_MODE, 32'h0000_0001);
		`CHK(second_output_pin, second_output_func)
	endtask

	task automatic t_home();
		wr(ADDR_HOME_TRG, 32'h0000_0001);
		`CHK(n_init, 0)
		wr(ADDR_UNLOCK, {16'h0000, UNLOCK_KEY});
		position_register_mode = 1'b1;
		wr(ADDR_HOME_TRG, 32'h0000_0001);
		`CHK(n_init, 0)
		position_register_mode = 1'b0;
		wr(ADDR_HOME_TRG, 32'h0000_0001);
		`CHK(n_init, 1)
	endtask

	task automatic t_refresh();
		wr(ADDR_FORMAT, 32'h0000_0002);
		wr(ADDR_REFRESH, {16'h0000, REFRESH_RESET});
		rd(ADDR_REFRESH, 32'h0000_0000);
		rd(ADDR_STATUS, {27'h0, enc_status});
		rd(ADDR_RES_1ST, enc_pulse);
		rd(ADDR_RES_2ND, 32'hFFFF_8000);
		`CHK(n_rst, 1)
		wr(ADDR_FORMAT, 32'h0000_0000);
		wr(ADDR_REFRESH, {16'h0000, REFRESH_READ});
		rd(ADDR_RES_1ST, user_unit_count);
		rd(ADDR_RES_2ND, 32'h0000_0000);
		`CHK(n_rst, 1)
	endtask

	task automatic t_frame(input bit pulse);
		logic [79:0] f;
		bit fl;
		wr(ADDR_FORMAT, {31'h0, pulse});
		wr(ADDR_DEBOUNCE, {31'h0, pulse});
		start_link(1'b1, {31'h0, pulse});
		`CHK(fourth_input_func, 1'b1)
		`CHK(second_output_pin, 1'b0)
		host.read_frame(1'b0, 0, f, fl);
		`CHK(fl, 1'b0)
		`CHK(f, exp_frame(pulse))
		repeat (ACK + 4) @(negedge clock);
		`CHK(readout_active, 1'b0)
		`CHK(second_output_pin, 1'b1)
		`CHK(readout_error_flag, 1'b0)
		stop_link();
	endtask

	task automatic t_timeout();
		logic [79:0] f;
		bit fl;
		start_link(1'b1, 1);
		host.read_frame(1'b1, TMO + 100, f, fl);
		`CHK(readout_error_flag, 1'b1)
		`CHK(readout_active, 1'b0)
		readout_enable = 1'b0;
		repeat (2) @(negedge clock);
		`CHK(readout_error_flag, 1'b0)
		repeat (RESTART) @(negedge clock);
	endtask

	// Low battery blocks a start and survives an enable cycle
	task automatic t_fault();
		enc_status = 5'h02;
		@(negedge clock);
		`CHK(readout_error_flag, 1'b1)
		start_link(1'b0, 1);
		stop_link();
		`CHK(readout_error_flag, 1'b1)
		enc_status = 5'h18;
		@(negedge clock);
		`CHK(readout_error_flag, 1'b0)
	endtask

	initial begin
		{nrst, param_wr, param_rd, position_register_mode, readout_enable} = 5'h00;
		{param_addr, param_wdata} = 48'h0;
		{second_output_func, third_output_func} = 2'h2;
		enc_status = 5'h18;
		enc_turns = 16'h8000;
		enc_pulse = 32'h0013_87FF;
		user_unit_count = 32'hFFF0_1234;
		repeat (3) @(negedge clock);
		nrst = 1'b1;
		t_regs();
		t_home();
		t_refresh();
		t_frame(1'b0);
		t_frame(1'b1);
		t_timeout();
		t_fault();
		stop_test();
	end
endmodule
`default_nettype wire
